// file: design/adc_channel_select_format.sv
/*
 channel decode, mux steering and sequencing of one shared converter.
 assumes the converter samples on ADC_START and answers with ADC_DONE;
 requests are synchronous to CLK.
*/
`default_nettype none
`include "adc_sel_defines.svh"
module adc_channel_select_format (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic [7:0] POS_CODE,
   input wire logic [7:0] NEG_CODE,
   input wire logic SECOND_ANALOG_OUTPUT_EN,
   input wire logic OLD_REVISION,
   output logic [2:0] MUX_POS_SRC,
   output logic [3:0] MUX_POS_LINE,
   output logic [2:0] MUX_NEG_SRC,
   output logic [3:0] MUX_NEG_LINE,
   output logic DIFFERENTIAL,
   output logic REF_IS_REGULATOR,
   output logic ADC_START,
   input wire logic ADC_DONE,
   input wire logic [`RAW_W-1:0] ADC_RAW,
   output logic [7:0] DIG_SEL,
   input wire logic [`WORD_W-1:0] DIG_DATA,
   output logic RSP_VALID,
   output logic [`WORD_W-1:0] RSP_DATA,
   output logic RSP_INVALID
);
   // -------------------------------------------------
   // decode helpers
   // -------------------------------------------------
   function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
      in_range = (c >= lo) && (c <= hi);
   endfunction

   function automatic adc_sel_pkg::pos_src_t pos_decode(input logic [7:0] c);
      if (in_range(c, `CH_FLEX_LO, `CH_FLEX_HI)) begin
         pos_decode = adc_sel_pkg::SRC_FLEX;
      end else if (in_range(c, `CH_EXT_LO, `CH_EXT_HI)) begin
         pos_decode = adc_sel_pkg::SRC_EXT;
      end else if (c == `CH_VREG) begin
         pos_decode = adc_sel_pkg::SRC_VREG;
      end else if (c == `CH_TEMP) begin
         pos_decode = adc_sel_pkg::SRC_TEMP;
      end else if (in_range(c, `CH_DIG_LO, `CH_DIG_HI)) begin
         pos_decode = adc_sel_pkg::SRC_DIG;
      end else begin
         pos_decode = adc_sel_pkg::SRC_NONE;
      end
   endfunction

   function automatic adc_sel_pkg::neg_src_t neg_decode(input logic [7:0] c);
      if (c == `CH_VREG || c == `CH_SE_ALT) begin
         neg_decode = adc_sel_pkg::NEG_GND;
      end else if (in_range(c, `CH_FLEX_LO, `CH_FLEX_HI)) begin
         neg_decode = adc_sel_pkg::NEG_FLEX;
      end else if (in_range(c, `CH_EXT_LO, `CH_EXT_HI)) begin
         neg_decode = adc_sel_pkg::NEG_EXT;
      end else if (c == `CH_VREF) begin
         neg_decode = adc_sel_pkg::NEG_VREF;
      end else begin
         neg_decode = adc_sel_pkg::NEG_NONE;
      end
   endfunction

   // digital and refused requests never touch the converter
   function automatic logic needs_conv(input adc_sel_pkg::pos_src_t p, input logic bad);
      needs_conv = !bad && (p != adc_sel_pkg::SRC_DIG);
   endfunction

   // -------------------------------------------------
   // request decode
   // -------------------------------------------------
   adc_sel_pkg::pos_src_t pos_src;
   adc_sel_pkg::neg_src_t neg_src;
   logic req_bad;
   logic old_dac_mode;
   logic take;

   assign old_dac_mode = OLD_REVISION && SECOND_ANALOG_OUTPUT_EN;
   assign pos_src = pos_decode(POS_CODE);
   assign neg_src = neg_decode(NEG_CODE);
   // reference negative is meaningless while the regulator is the reference
   assign req_bad = (pos_src == adc_sel_pkg::SRC_NONE)
      || (pos_src != adc_sel_pkg::SRC_DIG && neg_src == adc_sel_pkg::NEG_NONE)
      || (pos_src != adc_sel_pkg::SRC_DIG && old_dac_mode && neg_src == adc_sel_pkg::NEG_VREF);

   // -------------------------------------------------
   // sequencer
   // -------------------------------------------------
   adc_sel_pkg::state_t state_r;
   logic digital_r;
   logic bad_r;
   logic [`WORD_W-1:0] word;

   // only idle accepts, so conversions never overlap on the one converter
   assign REQ_READY = (state_r == adc_sel_pkg::ST_IDLE);
   assign take = REQ_VALID && REQ_READY;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_r <= adc_sel_pkg::ST_IDLE;
      end else begin
         case (state_r)
            adc_sel_pkg::ST_IDLE: begin
               if (take) begin
                  // digital and invalid requests skip the converter
                  if (!needs_conv(pos_src, req_bad)) begin
                     state_r <= adc_sel_pkg::ST_DONE;
                  end else begin
                     state_r <= adc_sel_pkg::ST_CONV;
                  end
               end
            end
            adc_sel_pkg::ST_CONV: begin
               if (ADC_DONE) begin
                  state_r <= adc_sel_pkg::ST_DONE;
               end
            end
            adc_sel_pkg::ST_DONE: begin
               state_r <= adc_sel_pkg::ST_IDLE;
            end
            default: begin
               state_r <= adc_sel_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // mux settings hold for the whole conversion
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         MUX_POS_SRC <= 3'h0;
         MUX_POS_LINE <= 4'h0;
         MUX_NEG_SRC <= 3'h0;
         MUX_NEG_LINE <= 4'h0;
         DIFFERENTIAL <= 1'b0;
         DIG_SEL <= 8'h00;
      end else if (take) begin
         MUX_POS_SRC <= req_bad ? 3'h0 : pos_src;
         MUX_POS_LINE <= POS_CODE[3:0];
         MUX_NEG_SRC <= req_bad ? 3'h0 : neg_src;
         MUX_NEG_LINE <= NEG_CODE[3:0];
         DIFFERENTIAL <= (neg_src != adc_sel_pkg::NEG_GND);
         DIG_SEL <= POS_CODE;
      end
   end

   // request kind kept for the answer stage
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         digital_r <= 1'b0;
         bad_r <= 1'b0;
      end else if (take) begin
         digital_r <= (pos_src == adc_sel_pkg::SRC_DIG);
         bad_r <= req_bad;
      end
   end

   // registered so the reference select never glitches with the enables
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         REF_IS_REGULATOR <= 1'b0;
      end else begin
         REF_IS_REGULATOR <= old_dac_mode;
      end
   end

   // one-cycle pulse: take is only true while idle
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ADC_START <= 1'b0;
      end else begin
         ADC_START <= take && needs_conv(pos_src, req_bad);
      end
   end

   // -------------------------------------------------
   // result
   // -------------------------------------------------
   result_format u_fmt (
      .raw(ADC_RAW),
      .digital(digital_r),
      .dig_word(DIG_DATA),
      .word(word)
   );

   // refused requests answer zero so no stale reading looks valid
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RSP_VALID <= 1'b0;
         RSP_DATA <= 16'h0000;
         RSP_INVALID <= 1'b0;
      end else begin
         RSP_VALID <= (state_r == adc_sel_pkg::ST_DONE);
         if (state_r == adc_sel_pkg::ST_DONE) begin
            RSP_DATA <= bad_r ? 16'h0000 : word;
            RSP_INVALID <= bad_r;
         end
      end
   end
endmodule
`default_nettype wire

// file: shared/adc_sel_defines.svh
/*
 channel codes, widths and timing counts for the channel select and
 result format block. assumes nothing beyond a SystemVerilog compiler.
*/
`ifndef ADC_SEL_DEFINES_SVH
`define ADC_SEL_DEFINES_SVH
`define CH_FLEX_LO 8'h00
`define CH_FLEX_HI 8'h07
`define CH_EXT_LO 8'h08
`define CH_EXT_HI 8'h0F
`define CH_TEMP 8'h1E
`define CH_VREG 8'h1F
`define CH_VREF 8'h1E
`define CH_SE_ALT 8'hC7
`define CH_DIG_LO 8'hC1
`define CH_DIG_HI 8'hF1
`define RAW_W 12
`define WORD_W 16
`define JUSTIFY_SHIFT 4
`define CONV_TIME_NS 2000
`define CLK_PERIOD_NS 25
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: shared/adc_sel_pkg.sv
/*
 types used by the channel select block in its decode and sequencer.
 assumes adc_sel_defines.svh is on the include path.
*/
`default_nettype none
package adc_sel_pkg;
   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_FLEX = 3'b001,
      SRC_EXT = 3'b010,
      SRC_TEMP = 3'b011,
      SRC_VREG = 3'b100,
      SRC_DIG = 3'b101
   } pos_src_t;
   typedef enum logic [2:0] {
      NEG_GND = 3'b000,
      NEG_FLEX = 3'b001,
      NEG_EXT = 3'b010,
      NEG_VREF = 3'b011,
      NEG_NONE = 3'b100
   } neg_src_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b10
   } state_t;
endpackage
`default_nettype wire

// file: design/result_format.sv
/*
 left-justifies a 12-bit converter sample into an unsigned 16-bit word.
 assumes the converter already gives offset binary for differential.
*/
`default_nettype none
`include "adc_sel_defines.svh"
module result_format (
   input wire logic [`RAW_W-1:0] raw,
   input wire logic digital,
   input wire logic [`WORD_W-1:0] dig_word,
   output logic [`WORD_W-1:0] word
);
   // converter samples read zero in the low four bits so the word steps by 16 from 0 to 65520; digital words pass dig_word as is
   always_comb begin
      if (digital) begin
         word = dig_word;
      end else begin
         word = {raw, {`JUSTIFY_SHIFT{1'b0}}};
      end
   end
endmodule
`default_nettype wire

// file: verif/adc_sel_checker.sv
/* port assertions for the channel select block
 assumes it is bound into the block by the bench top */
`default_nettype none
module adc_sel_checker (
   input wire logic CLK, RST_N, REQ_VALID, REQ_READY, SECOND_ANALOG_OUTPUT_EN, OLD_REVISION,
   input wire logic [7:0] POS_CODE, NEG_CODE, DIG_SEL,
   input wire logic [2:0] MUX_POS_SRC, MUX_NEG_SRC,
   input wire logic DIFFERENTIAL, REF_IS_REGULATOR, ADC_START, RSP_VALID, RSP_INVALID,
   input wire logic [15:0] RSP_DATA
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic take, ana, old_ref;
   assign take = REQ_VALID && REQ_READY;
   assign ana = take && POS_CODE < 8'h10;
   assign old_ref = OLD_REVISION && SECOND_ANALOG_OUTPUT_EN;
   sequence refused;
      !ADC_START ##1 RSP_VALID && RSP_INVALID && RSP_DATA == 16'h0000;
   endsequence
   a_start_from_take: assert property (ADC_START |-> $past(take))
      else $error("start without a request");
   a_one_converter: assert property (ADC_START |-> !REQ_READY)
      else $error("ready while converting");
   a_single_ended: assert property (ana && (NEG_CODE == 8'h1F || NEG_CODE == 8'hC7) |=> !DIFFERENTIAL)
      else $error("single-ended pair gave differential");
   a_diff_pair: assert property (ana && NEG_CODE < 8'h10 |=> DIFFERENTIAL && ADC_START)
      else $error("line pair not differential");
   a_vref_negative: assert property (ana && NEG_CODE == 8'h1E && !old_ref |=> MUX_NEG_SRC == 3'h3)
      else $error("reference not on negative input");
   a_digital_read: assert property (take && POS_CODE >= 8'hC1 && POS_CODE <= 8'hF1
      |=> MUX_POS_SRC == 3'h5 && DIG_SEL == $past(POS_CODE) && !ADC_START ##1 RSP_VALID && !RSP_INVALID)
      else $error("digital readout wrong");
   a_bad_code: assert property (take && POS_CODE > 8'hF1 |=> refused)
      else $error("bad code not refused");
   a_old_vref: assert property (ana && NEG_CODE == 8'h1E && old_ref |=> refused)
      else $error("reference code accepted on old part");
   a_ref_switch: assert property ($past(RST_N) |-> REF_IS_REGULATOR == $past(old_ref))
      else $error("reference select wrong");
   a_left_justify: assert property (RSP_VALID && !RSP_INVALID && MUX_POS_SRC != 3'h5
      |-> RSP_DATA[3:0] == 4'h0)
      else $error("result not left-justified");
endmodule
`default_nettype wire

// file: verif/conv_model.sv
/* converter model: answers each start pulse after a latency
 assumes starts never overlap */
`default_nettype none
module conv_model (
   input wire logic CLK, ADC_START,
   input wire logic [11:0] raw_val,
   input wire logic [3:0] lat,
   output var logic ADC_DONE,
   output var logic [11:0] ADC_RAW
);
   initial begin
      ADC_DONE = 1'b0;
      ADC_RAW = 12'h000;
   end
   always @(posedge CLK) begin
      if (ADC_START) begin
         repeat (lat) @(posedge CLK);
         ADC_DONE <= 1'b1;
         ADC_RAW <= raw_val;
         @(posedge CLK);
         ADC_DONE <= 1'b0;
         repeat (2) @(posedge CLK);
         // hold over: inverse so a late sample cannot pass
         ADC_RAW <= ~raw_val;
      end
   end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
/* bench for the channel select block with a converter model
 assumes design, model and checker compiled before it */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 1'b0, RST_N = 1'b0, REQ_VALID = 1'b0, SECOND_ANALOG_OUTPUT_EN = 1'b0, OLD_REVISION = 1'b0;
   logic REQ_READY, ADC_START, ADC_DONE, DIFFERENTIAL, REF_IS_REGULATOR, RSP_VALID, RSP_INVALID;
   logic [7:0] POS_CODE = 8'h00, NEG_CODE = 8'h00, DIG_SEL;
   logic [2:0] MUX_POS_SRC, MUX_NEG_SRC;
   logic [3:0] MUX_POS_LINE, MUX_NEG_LINE, lat = 4'h0;
   logic [11:0] ADC_RAW, raw_val = 12'h000;
   logic [15:0] DIG_DATA = 16'h0000, RSP_DATA;
   int err_total = 0, comparisons = 0;
   adc_channel_select_format dut (.*);
   conv_model conv (.*);
   initial forever #12.5 CLK = ~CLK;
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // host side maps the special negative code onto the reference code
   function automatic logic [7:0] host_neg(input logic [7:0] n);
      host_neg = (n == 8'h20) ? 8'h1E : n;
   endfunction
   // hold the request until taken, then a bounded wait for the answer
   task automatic req(input logic [7:0] p, n, input logic [15:0] exp, input logic inv, input logic [2:0] src,
                      input logic dif);
      int i;
      POS_CODE = p;
      NEG_CODE = n;
      REQ_VALID = 1'b1;
      do @(posedge CLK); while (REQ_READY !== 1'b1);
      #1 REQ_VALID = 1'b0;
      for (i = 0; i < 40 && RSP_VALID !== 1'b1; i++) @(posedge CLK) #1;
      check("valid", 16'h0001, {15'h0000, RSP_VALID});
      check("invalid", {15'h0000, inv}, {15'h0000, RSP_INVALID});
      // raw counts only: slope and offset stay with the host
      check("data", exp, RSP_DATA);
      if (!inv) check("pos src", {13'h0000, src}, {13'h0000, MUX_POS_SRC});
      if (!inv && src != 3'h5) check("diff", {15'h0000, dif}, {15'h0000, DIFFERENTIAL});
      @(posedge CLK) #1;
   endtask
   task automatic t_lines;
      raw_val = 12'hABC;
      req(8'h03, 8'h1F, 16'hABC0, 1'b0, 3'h1, 1'b0);
      lat = 4'h7;
      raw_val = 12'h123;
      req(8'h0B, 8'hC7, 16'h1230, 1'b0, 3'h2, 1'b0);
      check("pos line", 16'h000B, {12'h000, MUX_POS_LINE});
      raw_val = 12'h800;
      req(8'h0F, 8'h08, 16'h8000, 1'b0, 3'h2, 1'b1);
      check("neg src", 16'h0002, {13'h0000, MUX_NEG_SRC});
      req(8'h02, 8'h06, 16'h8000, 1'b0, 3'h1, 1'b1);
      check("neg src", 16'h0001, {13'h0000, MUX_NEG_SRC});
      check("neg line", 16'h0006, {12'h000, MUX_NEG_LINE});
   endtask
   task automatic t_internal;
      lat = 4'h0;
      raw_val = 12'hFFF;
      req(8'h1F, 8'hC7, 16'hFFF0, 1'b0, 3'h4, 1'b0);
      req(8'h1E, 8'h1F, 16'hFFF0, 1'b0, 3'h3, 1'b0);
      req(8'h05, host_neg(8'h20), 16'hFFF0, 1'b0, 3'h1, 1'b1);
      check("neg src", 16'h0003, {13'h0000, MUX_NEG_SRC});
   endtask
   task automatic t_digital;
      DIG_DATA = 16'h5A3C;
      req(8'hC1, 8'h00, 16'h5A3C, 1'b0, 3'h5, 1'b0);
      DIG_DATA = 16'hC3A5;
      req(8'hF1, 8'h05, 16'hC3A5, 1'b0, 3'h5, 1'b0);
      check("dig sel", 16'h00F1, {8'h00, DIG_SEL});
   endtask
   task automatic t_refused;
      logic [7:0] bad [5] = '{8'h10, 8'h1D, 8'h20, 8'hC0, 8'hF2};
      foreach (bad[k]) req(bad[k], 8'h1F, 16'h0000, 1'b1, 3'h0, 1'b0);
      req(8'h03, 8'h20, 16'h0000, 1'b1, 3'h0, 1'b0);
   endtask
   task automatic t_old_rev;
      OLD_REVISION = 1'b1;
      SECOND_ANALOG_OUTPUT_EN = 1'b1;
      @(posedge CLK) #1;
      check("ref reg", 16'h0001, {15'h0000, REF_IS_REGULATOR});
      req(8'h02, 8'h1E, 16'h0000, 1'b1, 3'h0, 1'b0);
      req(8'h02, 8'h1F, 16'hFFF0, 1'b0, 3'h1, 1'b0);
      OLD_REVISION = 1'b0;
      @(posedge CLK) #1;
      check("ref reg", 16'h0000, {15'h0000, REF_IS_REGULATOR});
   endtask
   task automatic finish_test;
      $display("mismatches %0d, comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge CLK);
      #1 RST_N = 1'b1;
      check("ready", 16'h0001, {15'h0000, REQ_READY});
      t_lines();
      t_internal();
      t_digital();
      t_refused();
      t_old_rev();
      finish_test();
   end
   initial begin
      #50us;
      err_total++;
      finish_test();
   end
endmodule
bind adc_channel_select_format adc_sel_checker chk (.*);
`default_nettype wire
